// File: shared/vpm_pkg.sv
package vpm_pkg;

  // Geometry
  localparam int NUM_PORTS = 16;
  localparam int NUM_VPORTS = 4;
  localparam int PIN_W = 8;

  // Global register byte addresses
  localparam logic [11:0] ADDR_MAP_A = 12'h0000;
  localparam logic [11:0] ADDR_MAP_B = 12'h0004;
  localparam logic [11:0] ADDR_CLKEV = 12'h0008;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h0010;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h0014;

  // Virtual port window: 0x040 + v*0x10, physical window: 0x200 + p*0x20
  localparam logic [5:0] VPORT_WIN = 6'h01;
  localparam logic [2:0] PPORT_WIN = 3'h1;

  // Offsets of registers inside one port window
  localparam logic [4:0] OFS_DIR = 5'h00;
  localparam logic [4:0] OFS_OUT = 5'h04;
  localparam logic [4:0] OFS_IN = 5'h08;
  localparam logic [4:0] OFS_FLAGS = 5'h0C;
  localparam logic [4:0] OFS_MASK0 = 5'h10;
  localparam logic [4:0] OFS_MASK1 = 5'h14;
  localparam logic [4:0] OFS_SENSE = 5'h18;

  // Field positions
  localparam int MAP_LO_LSB = 0;
  localparam int MAP_HI_LSB = 4;
  localparam int CLK_ROUTE_LSB = 0;
  localparam int EV_ROUTE_LSB = 4;
  localparam int SENSE_IBDIS_BIT = 2;
  localparam int ROUTED_PIN = 7;
  localparam logic [3:0] ROUTE_PORT_BASE = 4'h1;

  // Reset values
  localparam logic [7:0] MAP_RESET = 8'h00;
  localparam logic [1:0] ROUTE_RESET = 2'h0;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [2:0] SENSE_RESET = 3'h0;
  localparam logic [15:0] IRQ_RESET = 16'h0000;
  localparam logic [1:0] CLKEV_RSVD_ONES = 2'h3;
  localparam logic [1:0] ROUTE_OFF = 2'h0;

  // Sense modes
  localparam logic [1:0] SENSE_BOTH = 2'h0;
  localparam logic [1:0] SENSE_RISE = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_LOW = 2'h3;

  typedef enum logic [2:0] {
    PR_NONE,
    PR_DIR,
    PR_OUT,
    PR_IN,
    PR_FLAGS,
    PR_MASK0,
    PR_MASK1,
    PR_SENSE
  } vpm_reg_sel_t;

  // Write request toward one physical port
  typedef struct packed {
    logic en;
    vpm_reg_sel_t sel;
    logic [7:0] data;
  } vpm_port_wr_t;

  // State a physical port shows to the bus
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] out;
    logic [7:0] in;
    logic [1:0] flags;
    logic [7:0] mask0;
    logic [7:0] mask1;
    logic [2:0] sense;
  } vpm_port_view_t;

endpackage

// File: design/vpm_port.sv
`timescale 1ns/1ns
module vpm_port (
  input wire logic clk,
  input wire logic rst,
  input vpm_pkg::vpm_port_wr_t wr,
  input wire logic [7:0] pin_in,
  output vpm_pkg::vpm_port_view_t view,
  output logic flag_hit
);
  logic [7:0] dir_r;
  logic [7:0] out_r;
  logic [7:0] mask0_r;
  logic [7:0] mask1_r;
  logic [2:0] sense_r;
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] prev_r;
  logic [1:0] flags_r;
  logic [1:0] flags_nxt;
  logic [7:0] pin_ev;
  logic [1:0] hit;
  logic [1:0] clr;

  // Plain read/write registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_r <= vpm_pkg::PORT_RESET;
      out_r <= vpm_pkg::PORT_RESET;
      mask0_r <= vpm_pkg::PORT_RESET;
      mask1_r <= vpm_pkg::PORT_RESET;
      sense_r <= vpm_pkg::SENSE_RESET;
    end else if (wr.en) begin
      if (wr.sel == vpm_pkg::PR_DIR) dir_r <= wr.data;
      if (wr.sel == vpm_pkg::PR_OUT) out_r <= wr.data; // [R17]
      if (wr.sel == vpm_pkg::PR_MASK0) mask0_r <= wr.data;
      if (wr.sel == vpm_pkg::PR_MASK1) mask1_r <= wr.data;
      if (wr.sel == vpm_pkg::PR_SENSE) sense_r <= wr.data[2:0];
    end
  end

  // Two-stage pin synchroniser plus history for edge sense
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= vpm_pkg::PORT_RESET;
      sync2_r <= vpm_pkg::PORT_RESET;
      prev_r <= vpm_pkg::PORT_RESET;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Per-pin sense decode; disabled input buffer raises nothing
  always_comb begin
    pin_ev = '0;
    if (!sense_r[vpm_pkg::SENSE_IBDIS_BIT]) begin
      case (sense_r[1:0])
        vpm_pkg::SENSE_BOTH: pin_ev = sync2_r ^ prev_r;
        vpm_pkg::SENSE_RISE: pin_ev = sync2_r & ~prev_r;
        vpm_pkg::SENSE_FALL: pin_ev = ~sync2_r & prev_r;
        default: pin_ev = ~sync2_r;
      endcase
    end
  end

  assign hit = {|(pin_ev & mask1_r), |(pin_ev & mask0_r)}; // [R16]
  assign clr = (wr.en && wr.sel == vpm_pkg::PR_FLAGS) ? wr.data[1:0] : 2'h0;
  // Set beats write-one-to-clear in the same cycle
  assign flags_nxt = (flags_r & ~clr) | hit; // [R16]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) flags_r <= 2'h0;
    else flags_r <= flags_nxt;
  end

  assign flag_hit = |hit;
  // Input reads zero while its buffer is disabled
  assign view.in = sense_r[vpm_pkg::SENSE_IBDIS_BIT] ? 8'h00 : sync2_r; // [R14]
  assign view.dir = dir_r;
  assign view.out = out_r;
  assign view.flags = flags_r;
  assign view.mask0 = mask0_r;
  assign view.mask1 = mask1_r;
  assign view.sense = sense_r;
endmodule

// File: design/vpm_top.sv
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
// Notes on behaviour
// [R1] Upper nibble of first map register picks the port behind alias 1.
// [R2] Lower nibble of first map register picks the port behind alias 0.
// [R3] Upper nibble of second map register picks the port behind alias 3.
// [R4] Lower nibble of second map register picks the port behind alias 2.
// [R5] Alias registers behave exactly like the selected port's own registers.
// [R6] Select codes 0..15 index the sixteen ports in lettered order.
// [R7] Bits 7:6 and 3:2 of the route register read as one.
// [R8] Bits 5:4 route event channel 0 to pin 7 of port C, D or E.
// [R9] Software sets the pin as output before the event can appear.
// [R10] Bits 1:0 route the peripheral clock to pin 7 of port C, D or E.
// [R11] Clock wins over event when both pick the same pin.
// [R12] Software sets the pin as output before the clock can appear.
// [R13] Software keeps clock and event routes different.
// [R14] Alias input register shows synchronised pin levels while buffer enabled.
// [R15] Alias flag register bits 7:2 read as zero.
// [R16] Flags set on a sensed edge, or a low level in low sense mode, of a masked pin; write one clears.
// [R17] Output bit drives pin high on one, low on zero.
// [R18] Map changes steer the very next alias access, no added delay.
module vpm_top (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [127:0] PIN_IN,
  output logic [127:0] PIN_OUT,
  output logic [127:0] PIN_OE,
  input wire logic EVENT_CH0,
  output logic IRQ
);
  logic [7:0] map_a_r;
  logic [7:0] map_b_r;
  logic [1:0] clk_route_r;
  logic [1:0] ev_route_r;
  logic [15:0] irq_stat_r;
  logic [15:0] irq_mask_r;
  logic [31:0] rdata_r;
  logic err_r;
  logic [3:0] alias_sel [4];
  vpm_pkg::vpm_port_wr_t port_wr [vpm_pkg::NUM_PORTS];
  vpm_pkg::vpm_port_view_t port_view [vpm_pkg::NUM_PORTS];
  logic [15:0] port_hit;

  // Decoded access
  logic hit_map_a;
  logic hit_map_b;
  logic hit_clkev;
  logic hit_stat;
  logic hit_mask;
  logic hit_port;
  logic [3:0] tgt_port;
  vpm_pkg::vpm_reg_sel_t tgt_sel;
  logic [31:0] rd_val;
  logic dec_err;
  logic wr_go;
  logic lane0;

  // Alias selectors come straight from the map registers, no pipeline
  assign alias_sel[0] = map_a_r[vpm_pkg::MAP_LO_LSB +: 4]; // [R2]
  assign alias_sel[1] = map_a_r[vpm_pkg::MAP_HI_LSB +: 4]; // [R1]
  assign alias_sel[2] = map_b_r[vpm_pkg::MAP_LO_LSB +: 4]; // [R4]
  assign alias_sel[3] = map_b_r[vpm_pkg::MAP_HI_LSB +: 4]; // [R3]

  // Address decode; alias window resolves to a physical port index
  always_comb begin
    hit_map_a = 1'b0;
    hit_map_b = 1'b0;
    hit_clkev = 1'b0;
    hit_stat = 1'b0;
    hit_mask = 1'b0;
    hit_port = 1'b0;
    tgt_port = 4'h0;
    tgt_sel = vpm_pkg::PR_NONE;
    dec_err = 1'b0;
    if (PADDR[1:0] != 2'h0) begin
      dec_err = 1'b1;
    end else if (PADDR == vpm_pkg::ADDR_MAP_A) begin
      hit_map_a = 1'b1;
    end else if (PADDR == vpm_pkg::ADDR_MAP_B) begin
      hit_map_b = 1'b1;
    end else if (PADDR == vpm_pkg::ADDR_CLKEV) begin
      hit_clkev = 1'b1;
    end else if (PADDR == vpm_pkg::ADDR_IRQ_STATUS) begin
      hit_stat = 1'b1;
    end else if (PADDR == vpm_pkg::ADDR_IRQ_MASK) begin
      hit_mask = 1'b1;
    end else if (PADDR[11:6] == vpm_pkg::VPORT_WIN) begin
      // Only the four mirrored registers exist in an alias window
      hit_port = 1'b1;
      tgt_port = alias_sel[PADDR[5:4]]; // [R5] [R18]
      if ({1'b0, PADDR[3:0]} == vpm_pkg::OFS_DIR) tgt_sel = vpm_pkg::PR_DIR;
      else if ({1'b0, PADDR[3:0]} == vpm_pkg::OFS_OUT) tgt_sel = vpm_pkg::PR_OUT;
      else if ({1'b0, PADDR[3:0]} == vpm_pkg::OFS_IN) tgt_sel = vpm_pkg::PR_IN;
      else tgt_sel = vpm_pkg::PR_FLAGS;
    end else if (PADDR[11:9] == vpm_pkg::PPORT_WIN) begin
      hit_port = 1'b1;
      tgt_port = PADDR[8:5]; // [R6]
      if (PADDR[4:0] == vpm_pkg::OFS_DIR) tgt_sel = vpm_pkg::PR_DIR;
      else if (PADDR[4:0] == vpm_pkg::OFS_OUT) tgt_sel = vpm_pkg::PR_OUT;
      else if (PADDR[4:0] == vpm_pkg::OFS_IN) tgt_sel = vpm_pkg::PR_IN;
      else if (PADDR[4:0] == vpm_pkg::OFS_FLAGS) tgt_sel = vpm_pkg::PR_FLAGS;
      else if (PADDR[4:0] == vpm_pkg::OFS_MASK0) tgt_sel = vpm_pkg::PR_MASK0;
      else if (PADDR[4:0] == vpm_pkg::OFS_MASK1) tgt_sel = vpm_pkg::PR_MASK1;
      else if (PADDR[4:0] == vpm_pkg::OFS_SENSE) tgt_sel = vpm_pkg::PR_SENSE;
      else dec_err = 1'b1;
    end else begin
      dec_err = 1'b1;
    end
  end

  // Read mux, evaluated in the setup cycle
  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit_map_a) begin
      rd_val = {24'h00_0000, map_a_r};
    end else if (hit_map_b) begin
      rd_val = {24'h00_0000, map_b_r};
    end else if (hit_clkev) begin
      rd_val = {24'h00_0000, vpm_pkg::CLKEV_RSVD_ONES, ev_route_r,
                vpm_pkg::CLKEV_RSVD_ONES, clk_route_r}; // [R7]
    end else if (hit_stat) begin
      rd_val = {16'h0000, irq_stat_r};
    end else if (hit_mask) begin
      rd_val = {16'h0000, irq_mask_r};
    end else if (hit_port) begin
      case (tgt_sel)
        vpm_pkg::PR_DIR: rd_val = {24'h00_0000, port_view[tgt_port].dir};
        vpm_pkg::PR_OUT: rd_val = {24'h00_0000, port_view[tgt_port].out};
        vpm_pkg::PR_IN: rd_val = {24'h00_0000, port_view[tgt_port].in}; // [R14]
        vpm_pkg::PR_FLAGS: rd_val = {30'h0000_0000, port_view[tgt_port].flags}; // [R15]
        vpm_pkg::PR_MASK0: rd_val = {24'h00_0000, port_view[tgt_port].mask0};
        vpm_pkg::PR_MASK1: rd_val = {24'h00_0000, port_view[tgt_port].mask1};
        vpm_pkg::PR_SENSE: rd_val = {29'h0000_0000, port_view[tgt_port].sense};
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  // Read data and error are captured in setup so both come from flops
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      rdata_r <= PWRITE ? 32'h0000_0000 : rd_val;
      err_r <= dec_err;
    end
  end

  // Zero-wait slave: every access phase completes at once
  assign PREADY = PSEL & PENABLE;
  assign PRDATA = rdata_r;
  assign PSLVERR = PSEL & PENABLE & err_r;

  // Registers are 8 or 16 bits wide, so only low lanes matter
  assign wr_go = PSEL & PENABLE & PWRITE & ~dec_err;
  assign lane0 = PSTRB[0];

  // Map registers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      map_a_r <= vpm_pkg::MAP_RESET;
      map_b_r <= vpm_pkg::MAP_RESET;
    end else if (wr_go && lane0) begin
      if (hit_map_a) map_a_r <= PWDATA[7:0]; // [R1] [R2]
      if (hit_map_b) map_b_r <= PWDATA[7:0]; // [R3] [R4]
    end
  end

  // Route register; reserved bits are not stored
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      clk_route_r <= vpm_pkg::ROUTE_RESET;
      ev_route_r <= vpm_pkg::ROUTE_RESET;
    end else if (wr_go && lane0 && hit_clkev) begin
      clk_route_r <= PWDATA[vpm_pkg::CLK_ROUTE_LSB +: 2]; // [R10]
      ev_route_r <= PWDATA[vpm_pkg::EV_ROUTE_LSB +: 2]; // [R8]
    end
  end

  // Fan the single write out to the addressed physical port
  genvar gp;
  generate
    for (gp = 0; gp < vpm_pkg::NUM_PORTS; gp++) begin : g_port
      assign port_wr[gp].en = wr_go & lane0 & hit_port & (tgt_port == 4'(gp)); // [R5]
      assign port_wr[gp].sel = tgt_sel;
      assign port_wr[gp].data = PWDATA[7:0];

      vpm_port u_port (
        .clk(REF_CLK),
        .rst(RST),
        .wr(port_wr[gp]),
        .pin_in(PIN_IN[gp*8 +: 8]),
        .view(port_view[gp]),
        .flag_hit(port_hit[gp])
      );
    end
  endgenerate

  // Pin drive: pin 7 of ports C..E may carry the clock or the event
  logic clk_on;
  logic ev_on;
  logic [3:0] clk_port;
  logic [3:0] ev_port;
  assign clk_on = clk_route_r != vpm_pkg::ROUTE_OFF;
  assign ev_on = ev_route_r != vpm_pkg::ROUTE_OFF;
  assign clk_port = vpm_pkg::ROUTE_PORT_BASE + {2'h0, clk_route_r}; // [R10]
  assign ev_port = vpm_pkg::ROUTE_PORT_BASE + {2'h0, ev_route_r}; // [R8]

  genvar go;
  generate
    for (go = 0; go < vpm_pkg::NUM_PORTS; go++) begin : g_pin
      logic [7:0] drv;
      always_comb begin
        drv = port_view[go].out; // [R17]
        // Clock checked last so it overrides a clashing event route
        if (ev_on && ev_port == 4'(go)) drv[vpm_pkg::ROUTED_PIN] = EVENT_CH0; // [R8]
        if (clk_on && clk_port == 4'(go)) drv[vpm_pkg::ROUTED_PIN] = REF_CLK; // [R10] [R11]
      end
      assign PIN_OUT[go*8 +: 8] = drv;
      // Nothing reaches a pin unless its direction bit says output
      assign PIN_OE[go*8 +: 8] = port_view[go].dir; // [R9] [R12]
    end
  endgenerate

  // Sticky per-port interrupt status; a new hit beats a same-cycle clear
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      irq_stat_r <= vpm_pkg::IRQ_RESET;
      irq_mask_r <= vpm_pkg::IRQ_RESET;
    end else begin
      if (wr_go && hit_stat) begin
        irq_stat_r <= (irq_stat_r & ~PWDATA[15:0]) | port_hit;
      end else begin
        irq_stat_r <= irq_stat_r | port_hit;
      end
      if (wr_go && hit_mask) irq_mask_r <= PWDATA[15:0];
    end
  end

  assign IRQ = |(irq_stat_r & irq_mask_r);
endmodule

// File: testbench/vpm_props.sv
`timescale 1ns/1ns
module vpm_props (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [127:0] PIN_OUT,
  input wire logic [127:0] PIN_OE,
  input wire logic EVENT_CH0,
  input wire logic IRQ
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  logic [7:0] map_a_r, map_b_r, route_r, dat_r;
  logic [15:0] mask_r;
  logic [3:0] tgt, tgt_r;
  logic wr, win_v, win_p;
  logic [6:0] clk_bit, ev_bit;
  // Decode of the transfer in flight
  assign wr = PSEL && PENABLE && PWRITE && PADDR[1:0] == 2'h0;
  assign win_v = PADDR[11:6] == vpm_pkg::VPORT_WIN;
  assign win_p = PADDR[11:9] == vpm_pkg::PPORT_WIN;
  assign clk_bit = 7'(route_r[1:0]) * 7'h08 + 7'h0F; // Pin 7 of port route+1
  assign ev_bit = 7'(route_r[5:4]) * 7'h08 + 7'h0F;
  // Alias number picks a nibble of the mirrored map
  always_comb begin
    case (PADDR[5:4])
      2'h0: tgt = map_a_r[3:0];
      2'h1: tgt = map_a_r[7:4];
      2'h2: tgt = map_b_r[3:0];
      default: tgt = map_b_r[7:4];
    endcase
  end
  // Shadow of byte registers; strobe 0 gates them as in the design
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      map_a_r <= 8'h00;
      map_b_r <= 8'h00;
      route_r <= 8'h00;
    end else if (wr && PSTRB[0]) begin
      if (PADDR == vpm_pkg::ADDR_MAP_A) map_a_r <= PWDATA[7:0];
      if (PADDR == vpm_pkg::ADDR_MAP_B) map_b_r <= PWDATA[7:0];
      if (PADDR == vpm_pkg::ADDR_CLKEV) route_r <= PWDATA[7:0];
    end
  end
  // Mask ignores strobes, so it is tracked apart
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) mask_r <= 16'h0000;
    else if (wr && PADDR == vpm_pkg::ADDR_IRQ_MASK) mask_r <= PWDATA[15:0];
  end
  // Target port and data of the last cycle, for one-cycle-later checks
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tgt_r <= 4'h0;
      dat_r <= 8'h00;
    end else begin
      tgt_r <= win_v ? tgt : PADDR[8:5];
      dat_r <= PWDATA[7:0];
    end
  end
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence access_s;
    PSEL && PENABLE;
  endsequence
  a_ready_next: assert property (setup_s ##1 access_s |-> PREADY)
    else $error("ready missing in access");
  a_err_unaligned: assert property (PSEL && PENABLE && PADDR[1:0] != 2'h0 |-> PSLVERR)
    else $error("unaligned access not refused");
  a_rsvd_ones: assert property ((PSEL && !PENABLE && !PWRITE && PADDR == vpm_pkg::ADDR_CLKEV)
    ##1 access_s
    |-> PRDATA[7:6] == 2'h3 && PRDATA[3:2] == 2'h3) else $error("route reserved bits not one");
  a_flag_zeros: assert property ((PSEL && !PENABLE && !PWRITE && win_v && PADDR[3:0] == 4'hC)
    ##1 access_s
    |-> PRDATA[7:2] == 6'h00) else $error("flag upper bits not zero");
  a_dir_phys: assert property (wr && PSTRB[0] && win_p && PADDR[4:0] == vpm_pkg::OFS_DIR
    |=> PIN_OE[{tgt_r, 3'h0} +: 8] == dat_r) else $error("direction write lost");
  a_dir_alias: assert property (wr && PSTRB[0] && win_v && PADDR[3:0] == 4'h0
    |=> PIN_OE[{tgt_r, 3'h0} +: 8] == dat_r) else $error("alias direction misrouted");
  a_out_drive: assert property (wr && PSTRB[0] && win_p && PADDR[4:0] == vpm_pkg::OFS_OUT
    |=> PIN_OUT[{tgt_r, 3'h0} +: 7] == dat_r[6:0]) else $error("pin drive wrong");
  a_event_pin: assert property (route_r[5:4] != 2'h0 && route_r[5:4] != route_r[1:0]
    |-> PIN_OUT[ev_bit] == EVENT_CH0) else $error("event not on pin");
  a_clock_pin: assert property (@(negedge REF_CLK) disable iff (RST)
    route_r[1:0] != 2'h0 |-> PIN_OUT[clk_bit]) else $error("clock not on pin");
  a_irq_masked: assert property (mask_r == 16'h0000 |-> !IRQ)
    else $error("interrupt while fully masked");
endmodule

bind vpm_top vpm_props u_props (.REF_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .PSTRB, .PRDATA, .PREADY, .PSLVERR, .PIN_OUT, .PIN_OE, .EVENT_CH0, .IRQ);

// File: testbench/vpm_top_tb_top.sv
`timescale 1ns/1ns
module vpm_top_tb_top;
  logic REF_CLK, RST, PSEL, PENABLE, PWRITE, EVENT_CH0, PREADY, PSLVERR, IRQ, er;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [3:0] PSTRB;
  logic [127:0] PIN_IN, PIN_OUT, PIN_OE;
  logic [3:0] pm [4];
  logic [7:0] d;
  int n_fail, samples_checked, seed, p, v, k, q;

  vpm_top u_dut (.REF_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
    .PRDATA, .PREADY, .PSLVERR, .PIN_IN, .PIN_OUT, .PIN_OE, .EVENT_CH0, .IRQ);

  // Byte addresses of physical and alias registers
  function automatic logic [11:0] pa(input int p, input logic [4:0] o);
    return 12'h200 + 12'(p * 32) + 12'(o);
  endfunction
  function automatic logic [11:0] va(input int v, input logic [4:0] o);
    return 12'h040 + 12'(v * 16) + 12'(o);
  endfunction
  // Route register read-back: reserved pairs always one
  function automatic logic [31:0] route_exp(input logic [1:0] ev, input logic [1:0] c);
    return {24'h0000_00, 2'h3, ev, 2'h3, c};
  endfunction

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; a bounded wait guards against a missing ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] s);
    int n;
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    PSTRB <= s;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    if (PREADY !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 4'hF);
    chk(rd, e);
  endtask

  // Free-running reference clock
  initial begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end

  initial begin
    seed = 35961;
    RST = 1'b1;
    {PSEL, PENABLE, PWRITE, EVENT_CH0} = 4'h0;
    PADDR = 12'h000;
    PWDATA = 32'h0000_0000;
    PSTRB = 4'h0;
    PIN_IN = 128'h0;
    repeat (12) @(posedge REF_CLK);
    RST <= 1'b0;
    rchk(vpm_pkg::ADDR_CLKEV, route_exp(2'h0, 2'h0));
    // Every select code lands on one alias; others random
    for (k = 0; k < 16; k++) begin
      for (v = 0; v < 4; v++) pm[v] = 4'($random(seed));
      v = k % 4;
      pm[v] = 4'(k);
      apb(1'b1, vpm_pkg::ADDR_MAP_A, {24'h0000_00, pm[1], pm[0]}, 4'h1);
      apb(1'b1, vpm_pkg::ADDR_MAP_B, {24'h0000_00, pm[3], pm[2]}, 4'h1);
      d = 8'($random(seed));
      apb(1'b1, va(v, vpm_pkg::OFS_DIR), {24'h0000_00, d}, 4'h1);
      rchk(pa(pm[v], vpm_pkg::OFS_DIR), {24'h0000_00, d});
      chk(32'(PIN_OE[pm[v] * 8 +: 8]), {24'h0000_00, d});
      apb(1'b1, pa(pm[v], vpm_pkg::OFS_OUT), {24'h0000_00, ~d}, 4'h1);
      rchk(va(v, vpm_pkg::OFS_OUT), {24'h0000_00, ~d});
      chk(32'(PIN_OUT[pm[v] * 8 +: 8]), {24'h0000_00, ~d});
      PIN_IN <= {$random(seed), $random(seed), $random(seed), $random(seed)};
      repeat (3) @(posedge REF_CLK);
      rchk(va(v, vpm_pkg::OFS_IN), {24'h0000_00, PIN_IN[pm[v] * 8 +: 8]});
    end
    // Strobe-less write, unmapped and unaligned places are refused
    apb(1'b1, va(0, vpm_pkg::OFS_DIR), 32'h0000_003C, 4'h1);
    apb(1'b1, va(0, vpm_pkg::OFS_DIR), 32'h0000_00C3, 4'h0);
    rchk(va(0, vpm_pkg::OFS_DIR), 32'h0000_003C);
    rchk(12'h100, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
    apb(1'b1, va(1, vpm_pkg::OFS_DIR) + 12'h001, 32'h0000_00FF, 4'h1);
    chk(32'(er), 32'h0000_0001);
    // Disabled input buffer reads zero
    p = pm[0];
    apb(1'b1, pa(p, vpm_pkg::OFS_SENSE), 32'h0000_0004, 4'h1);
    rchk(va(0, vpm_pkg::OFS_IN), 32'h0000_0000);
    // Rising edge on pin 7 sets flag 1; mask, clear and interrupt line
    PIN_IN <= 128'h0;
    apb(1'b1, pa(p, vpm_pkg::OFS_SENSE), 32'h0000_0001, 4'h1);
    apb(1'b1, pa(p, vpm_pkg::OFS_MASK1), 32'h0000_0080, 4'h1);
    PIN_IN[p * 8 + 7] <= 1'b1;
    repeat (5) @(posedge REF_CLK);
    rchk(va(0, vpm_pkg::OFS_FLAGS), 32'h0000_0002);
    chk(32'(IRQ), 32'h0000_0000);
    apb(1'b1, vpm_pkg::ADDR_IRQ_MASK, 32'(1 << p), 4'h0);
    @(negedge REF_CLK);
    chk(32'(IRQ), 32'h0000_0001);
    apb(1'b1, va(0, vpm_pkg::OFS_FLAGS), 32'h0000_00FF, 4'h1);
    rchk(va(0, vpm_pkg::OFS_FLAGS), 32'h0000_0000);
    apb(1'b1, vpm_pkg::ADDR_IRQ_STATUS, 32'(1 << p), 4'h1);
    @(negedge REF_CLK);
    chk(32'(IRQ), 32'h0000_0000);
    // Each route code: event alone, then clock on the same pin
    for (k = 0; k < 4; k++) begin
      q = k + 1;
      apb(1'b1, pa(q, vpm_pkg::OFS_DIR), 32'h0000_0080, 4'h1);
      apb(1'b1, vpm_pkg::ADDR_CLKEV, 32'h0000_00CC | 32'(k << 4), 4'h1);
      rchk(vpm_pkg::ADDR_CLKEV, route_exp(2'(k), 2'h0));
      @(posedge REF_CLK);
      EVENT_CH0 <= 1'b1;
      @(negedge REF_CLK);
      if (k > 0) chk(32'(PIN_OUT[q * 8 + 7]), 32'h0000_0001);
      chk(32'(PIN_OE[q * 8 + 7]), 32'h0000_0001);
      apb(1'b1, vpm_pkg::ADDR_CLKEV, 32'(k << 4) | 32'(k), 4'h1);
      rchk(vpm_pkg::ADDR_CLKEV, route_exp(2'(k), 2'(k)));
      @(negedge REF_CLK);
      #2;
      if (k > 0) chk(32'(PIN_OUT[q * 8 + 7]), 32'h0000_0000);
      @(posedge REF_CLK);
      #2;
      if (k > 0) chk(32'(PIN_OUT[q * 8 + 7]), 32'h0000_0001);
      EVENT_CH0 <= 1'b0;
    end
    give_verdict();
  end
endmodule
